// ==== pcs_pkg.sv ====
// Constants for the second capability register bank
package pcs_pkg;
  // Byte addresses of the register words
  localparam logic [7:0] PCS_OFF_DEV_CAP = 8'he4;
  localparam logic [7:0] PCS_OFF_DEV_CTL = 8'he8;
  localparam logic [7:0] PCS_OFF_LNK_CAP = 8'hec;
  localparam logic [7:0] PCS_OFF_LNK_CTL = 8'hf0;
  localparam logic [7:0] PCS_OFF_SLT_CAP = 8'hf4;
  localparam logic [7:0] PCS_OFF_SLT_CTL = 8'hf8;
  localparam logic [7:0] PCS_OFF_PRELOAD = 8'hfc;
  // Device capabilities field positions
  localparam int PCS_DCAP_LTR_BIT = 11;
  localparam int PCS_DCAP_FCU_BIT = 12;
  localparam int PCS_DCAP_HINT_LO = 18;
  // Device control field positions
  localparam int PCS_DCTL_LTR_EN_BIT = 10;
  localparam int PCS_DCTL_HINT_EN_LO = 13;
  // Link control and status field positions
  localparam int PCS_LCTL_SPEED_LO = 0;
  localparam int PCS_LCTL_COMPL_BIT = 4;
  localparam int PCS_LCTL_AUTOSPD_BIT = 5;
  localparam int PCS_LCTL_DEEMP_BIT = 6;
  localparam int PCS_LCTL_MARGIN_LO = 7;
  localparam int PCS_LCTL_MODCOMP_BIT = 10;
  localparam int PCS_LCTL_SOS_BIT = 11;
  localparam int PCS_LCTL_CDEEMP_BIT = 12;
  localparam int PCS_LSTS_DEEMP_BIT = 16;
  // Preload word field positions
  localparam int PCS_PRE_FCU_BIT = 0;
  localparam int PCS_PRE_HINT_LO = 1;
  localparam int PCS_PRE_DEEMP_BIT = 3;
  // Values after reset
  localparam logic PCS_RST_LTR_SUP = 1'h1;
  localparam logic PCS_RST_FCU = 1'h0;
  localparam logic [1:0] PCS_RST_HINT_SUP = 2'h0;
  localparam logic PCS_RST_LTR_EN = 1'h0;
  localparam logic [1:0] PCS_RST_HINT_EN = 2'h0;
  localparam logic [3:0] PCS_RST_SPEED = 4'h2;
  localparam logic [2:0] PCS_RST_MARGIN = 3'h0;
  localparam logic PCS_RST_DEEMP_UP = 1'h0;
  localparam logic PCS_RST_DEEMP_DN = 1'h1;
  // AXI responses
  localparam logic [1:0] PCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;
  // Bus handshake states
  typedef enum logic [2:0] {
    PCS_ST_IDLE = 3'b001,
    PCS_ST_RESP = 3'b010,
    PCS_ST_HOLD = 3'b100
  } pcs_state_t;
endpackage

// ==== pcs_axi_wr.sv ====
// AXI4-Lite write channel collector: takes address and data in either order
`timescale 1ns/1ps
`default_nettype none
module pcs_axi_wr
  import pcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_bresp_err,
  output logic [1:0] o_bresp,
  output logic o_wr_go,
  output logic [7:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb
);
  // Which halves of the write have arrived
  logic have_a;
  logic have_d;
  logic bvalid;
  logic [1:0] bresp;
  // Captured halves, kept for when the other half arrives later
  logic [7:0] addr_q;
  logic [31:0] data_q;
  logic [3:0] strb_q;
  wire take_a = i_awvalid && !have_a && !bvalid;
  wire take_d = i_wvalid && !have_d && !bvalid;
  wire next_a = have_a || take_a;
  wire next_d = have_d || take_d;
  // Write fires once both halves are held
  wire go = next_a && next_d && !bvalid;

  assign o_awready = !have_a && !bvalid;
  assign o_wready = !have_d && !bvalid;
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_wr_go = go;
  // A half taken on the firing edge passes straight through, so no stale word is written
  assign o_wr_addr = take_a ? i_awaddr : addr_q;
  assign o_wr_data = take_d ? i_wdata : data_q;
  assign o_wr_strb = take_d ? i_wstrb : strb_q;

  // Capture address and data, then raise the response
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      have_a <= 1'b0;
      have_d <= 1'b0;
      bvalid <= 1'b0;
      bresp <= PCS_RESP_OKAY;
      addr_q <= 8'h00;
      data_q <= 32'h0000_0000;
      strb_q <= 4'h0;
    end
    else
    begin
      if (take_a)
        addr_q <= i_awaddr;
      if (take_d)
      begin
        data_q <= i_wdata;
        strb_q <= i_wstrb;
      end
      if (go)
      begin
        have_a <= 1'b0;
        have_d <= 1'b0;
        bvalid <= 1'b1;
        bresp <= i_bresp_err ? PCS_RESP_SLVERR : PCS_RESP_OKAY;
      end
      else
      begin
        have_a <= next_a;
        have_d <= next_d;
        if (bvalid && i_bready)
          bvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== pcs_regs.sv ====
// Second capability register bank with AXI4-Lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pcs_regs
  import pcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_downstream,
  input wire logic i_cur_deemp,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_ltr_en,
  output logic [1:0] o_hint_en,
  output logic [3:0] o_target_speed,
  output logic o_enter_compliance,
  output logic o_autospeed_dis,
  output logic o_deemp_sel,
  output logic [2:0] o_margin,
  output logic o_mod_compliance,
  output logic o_compliance_sos,
  output logic o_compliance_deemp
);
  // Write side handshake results
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  // Preloaded read-only values
  logic fcu_cap;
  logic [1:0] hint_sup;
  logic deemp_sel;
  // Strap caught once after reset release
  logic strap_done;
  // Writable control fields
  logic ltr_en;
  logic [1:0] hint_en;
  logic [3:0] speed;
  logic compl;
  logic autospd;
  logic [2:0] margin;
  logic modcomp;
  logic sos;
  logic cdeemp;
  // Live de-emphasis status
  logic cur_deemp;
  // Read channel state
  pcs_state_t rd_state;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // Address decode, word aligned
  wire [7:0] wa = {wr_addr[7:2], 2'b00};
  wire hit_dctl = (wa == PCS_OFF_DEV_CTL);
  wire hit_lctl = (wa == PCS_OFF_LNK_CTL);
  wire hit_pre = (wa == PCS_OFF_PRELOAD);
  wire wr_known = hit_dctl || hit_lctl || hit_pre
    || (wa == PCS_OFF_DEV_CAP) || (wa == PCS_OFF_LNK_CAP)
    || (wa == PCS_OFF_SLT_CAP) || (wa == PCS_OFF_SLT_CTL);
  wire wr_dctl_b1 = wr_go && hit_dctl && wr_strb[1];
  wire wr_lctl_b0 = wr_go && hit_lctl && wr_strb[0];
  wire wr_lctl_b1 = wr_go && hit_lctl && wr_strb[1];
  wire wr_pre_b0 = wr_go && hit_pre && wr_strb[0];

  pcs_axi_wr u_wr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_bresp_err(!wr_known),
    .o_bresp(o_bresp),
    .o_wr_go(wr_go),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb)
  );

  // Register words as read; unimplemented bits are zero
  wire [31:0] w_dcap = {12'h000, hint_sup, 5'h00, fcu_cap, PCS_RST_LTR_SUP,
    11'h000};
  wire [31:0] w_dctl = {16'h0000, 1'b0, hint_en, 2'b00, ltr_en,
    10'h000};
  wire [31:0] w_lctl = {15'h0000, cur_deemp, 3'b000, cdeemp, sos, modcomp,
    margin, deemp_sel, autospd, compl, speed};
  wire [31:0] w_pre = {28'h0000000, deemp_sel, hint_sup, fcu_cap};
  wire [7:0] ra = {i_araddr[7:2], 2'b00};
  wire rd_known = (ra == PCS_OFF_DEV_CAP) || (ra == PCS_OFF_DEV_CTL)
    || (ra == PCS_OFF_LNK_CAP) || (ra == PCS_OFF_LNK_CTL)
    || (ra == PCS_OFF_SLT_CAP) || (ra == PCS_OFF_SLT_CTL)
    || (ra == PCS_OFF_PRELOAD);
  wire [31:0] rd_mux = (ra == PCS_OFF_DEV_CAP) ? w_dcap :
    (ra == PCS_OFF_DEV_CTL) ? w_dctl :
    (ra == PCS_OFF_LNK_CTL) ? w_lctl :
    (ra == PCS_OFF_PRELOAD) ? w_pre : 32'h0000_0000;

  assign o_arready = (rd_state == PCS_ST_IDLE);
  assign o_rvalid = (rd_state == PCS_ST_RESP);
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_ltr_en = ltr_en;
  assign o_hint_en = hint_en;
  assign o_target_speed = speed;
  assign o_enter_compliance = compl;
  assign o_autospeed_dis = autospd;
  assign o_deemp_sel = deemp_sel;
  assign o_margin = margin;
  assign o_mod_compliance = modcomp;
  assign o_compliance_sos = sos;
  assign o_compliance_deemp = cdeemp;

  // Read channel: one read at a time, answer one cycle after acceptance
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_state <= PCS_ST_IDLE;
      rdata <= 32'h0000_0000;
      rresp <= PCS_RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        PCS_ST_IDLE:
        begin
          if (i_arvalid)
          begin
            rdata <= rd_mux;
            rresp <= rd_known ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
            rd_state <= PCS_ST_RESP;
          end
        end
        PCS_ST_RESP:
        begin
          if (i_rready)
            rd_state <= PCS_ST_IDLE;
        end
        default:
          rd_state <= PCS_ST_IDLE;
      endcase
    end
  end

  // Preloadable read-only defaults; direction strap sampled after release
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fcu_cap <= PCS_RST_FCU;
      hint_sup <= PCS_RST_HINT_SUP;
      deemp_sel <= PCS_RST_DEEMP_UP;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      // Downstream ports start with select set
      deemp_sel <= i_downstream ? PCS_RST_DEEMP_DN : PCS_RST_DEEMP_UP;
      strap_done <= 1'b1;
    end
    else if (wr_pre_b0)
    begin
      // Loader path replaces defaults
      fcu_cap <= wr_data[PCS_PRE_FCU_BIT];
      hint_sup <= wr_data[PCS_PRE_HINT_LO +: 2];
      deemp_sel <= wr_data[PCS_PRE_DEEMP_BIT];
    end
  end

  // Current de-emphasis: direction value until link reports
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cur_deemp <= PCS_RST_DEEMP_UP;
    else if (!strap_done)
      cur_deemp <= i_downstream ? PCS_RST_DEEMP_DN : PCS_RST_DEEMP_UP;
    else
      cur_deemp <= i_cur_deemp;
  end

  // Device control writable fields
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ltr_en <= PCS_RST_LTR_EN;
      hint_en <= PCS_RST_HINT_EN;
    end
    else if (wr_dctl_b1)
    begin
      ltr_en <= wr_data[PCS_DCTL_LTR_EN_BIT];
      hint_en <= wr_data[PCS_DCTL_HINT_EN_LO +: 2];
    end
  end

  // Link control writable fields, per byte lane
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      speed <= PCS_RST_SPEED;
      compl <= 1'b0;
      autospd <= 1'b0;
      margin <= PCS_RST_MARGIN;
      modcomp <= 1'b0;
      sos <= 1'b0;
      cdeemp <= 1'b0;
    end
    else
    begin
      if (wr_lctl_b0)
      begin
        speed <= wr_data[PCS_LCTL_SPEED_LO +: 4];
        compl <= wr_data[PCS_LCTL_COMPL_BIT];
        autospd <= wr_data[PCS_LCTL_AUTOSPD_BIT];
        margin[0] <= wr_data[PCS_LCTL_MARGIN_LO];
      end
      if (wr_lctl_b1)
      begin
        margin[2:1] <= wr_data[PCS_LCTL_MARGIN_LO + 1 +: 2];
        modcomp <= wr_data[PCS_LCTL_MODCOMP_BIT];
        sos <= wr_data[PCS_LCTL_SOS_BIT];
        cdeemp <= wr_data[PCS_LCTL_CDEEMP_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// ==== pcs_regs_sva.sv ====
// Checker of the second capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_sva
  import pcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_downstream,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_ltr_en,
  input wire logic [1:0] o_hint_en,
  input wire logic o_deemp_sel
);
  // Address of the read in flight
  logic [7:0] rd_addr;
  // Keep the read address from its acceptance
  always_ff @(posedge i_clk)
  begin
    if (i_arvalid && o_arready)
    begin
      rd_addr <= i_araddr;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Address and data taken at one edge
  sequence s_wr(a);
    i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr == a;
  endsequence
  // Read answer for one word
  sequence s_rd(a);
    o_rvalid && rd_addr == a;
  endsequence
  a_strap_select: assert property ($rose(i_rst_n) |=> o_deemp_sel == $past(i_downstream))
    else $error("select level differs from strap");
  a_ctl_reset: assert property ($past(!i_rst_n) |-> !o_ltr_en && o_hint_en == 2'h0)
    else $error("controls not cleared by reset");
  a_ctl_write: assert property (s_wr(PCS_OFF_DEV_CTL) ##0 i_wstrb[1]
    |=> o_ltr_en == $past(i_wdata[10]) && o_hint_en == $past(i_wdata[14:13]))
    else $error("controls do not follow write");
  a_ctl_gated: assert property (s_wr(PCS_OFF_DEV_CTL) ##0 !i_wstrb[1]
    |=> $stable(o_ltr_en) && $stable(o_hint_en))
    else $error("controls changed without lane");
  a_select_ro: assert property (s_wr(PCS_OFF_LNK_CTL) |=> $stable(o_deemp_sel))
    else $error("select changed by link write");
  a_preload_sel: assert property (s_wr(PCS_OFF_PRELOAD) ##0 i_wstrb[0]
    |=> o_deemp_sel == $past(i_wdata[3]))
    else $error("select not preloaded");
  a_cap_fixed: assert property (s_rd(PCS_OFF_DEV_CAP)
    |-> o_rdata[11] && o_rdata[10:0] == 11'h0 && o_rdata[31:20] == 12'h0)
    else $error("fixed capability bits wrong");
  a_link_zero: assert property (s_rd(PCS_OFF_LNK_CTL)
    |-> o_rdata[31:17] == 15'h0 && o_rdata[15:13] == 3'h0)
    else $error("link status spare bits set");
  a_blank_words: assert property (o_rvalid && rd_addr inside {8'hec, 8'hf4, 8'hf8}
    |-> o_rdata == 32'h0)
    else $error("blank word reads nonzero");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered next cycle");
endmodule
// Attach to every instance of the bank
bind pcs_regs pcs_regs_sva chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_downstream(i_downstream),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_ltr_en(o_ltr_en), .o_hint_en(o_hint_en),
  .o_deemp_sel(o_deemp_sel)
);
`default_nettype wire

// ==== pcs_regs_bench.sv ====
// Self-checking bench for the second capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_bench
  import pcs_pkg::*;
;
  logic i_clk, i_rst_n, i_downstream, i_cur_deemp, i_awvalid, i_wvalid, i_bready;
  logic i_arvalid, i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0] i_awaddr, i_araddr;
  logic [2:0] i_awprot, i_arprot, o_margin;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb, o_target_speed;
  logic [1:0] o_bresp, o_rresp, o_hint_en;
  logic o_ltr_en, o_enter_compliance, o_autospeed_dis, o_deemp_sel;
  logic o_mod_compliance, o_compliance_sos, o_compliance_deemp;
  int mismatches, checks;
  logic dn; // Port direction strap in use
  pcs_regs dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_downstream(i_downstream), .i_cur_deemp(i_cur_deemp),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(i_awprot),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(i_arprot),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_ltr_en(o_ltr_en), .o_hint_en(o_hint_en), .o_target_speed(o_target_speed),
    .o_enter_compliance(o_enter_compliance), .o_autospeed_dis(o_autospeed_dis),
    .o_deemp_sel(o_deemp_sel), .o_margin(o_margin), .o_mod_compliance(o_mod_compliance),
    .o_compliance_sos(o_compliance_sos), .o_compliance_deemp(o_compliance_deemp)
  );
  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Compare one value
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Print counts and verdict, then end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One cycle of a bounded wait
  task automatic guard(inout int n);
    @(posedge i_clk);
    n++;
    if (n > 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // Bus write with expected response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      guard(n);
      if (o_awready)
        i_awvalid <= 1'b0;
      if (o_wready)
        i_wvalid <= 1'b0;
    end
    while (!o_bvalid);
    i_bready <= 1'b0;
    chk("bresp", 32'(o_bresp), 32'(r));
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      guard(n);
      if (o_arready)
        i_arvalid <= 1'b0;
    end
    while (!o_rvalid);
    i_rready <= 1'b0;
    chk("rdata", o_rdata, e);
    chk("rresp", 32'(o_rresp), 32'(r));
  endtask
  // Reset with a given port direction
  task automatic do_reset(input logic d);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_downstream <= d;
    i_cur_deemp <= d;
    dn = d;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  // Direction dependent link bits 6 and 16
  function automatic logic [31:0] dsel();
    return {15'h0, dn, 9'h0, dn, 6'h0};
  endfunction
  // Values right after reset
  task automatic t_defaults();
    rd(PCS_OFF_DEV_CAP, 32'h0000_0800, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CTL, 32'h0, PCS_RESP_OKAY);
    rd(PCS_OFF_LNK_CAP, 32'h0, PCS_RESP_OKAY);
    rd(PCS_OFF_LNK_CTL, 32'h2 | dsel(), PCS_RESP_OKAY);
    rd(PCS_OFF_SLT_CAP, 32'h0, PCS_RESP_OKAY);
    rd(PCS_OFF_SLT_CTL, 32'h0, PCS_RESP_OKAY);
    chk("select", 32'(o_deemp_sel), 32'(dn));
    $display("defaults done");
  endtask
  // Writable controls and lane gating
  task automatic t_controls();
    wr(PCS_OFF_DEV_CTL, 32'hffff_ffff, 4'hf, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CTL, 32'h0000_6400, PCS_RESP_OKAY);
    chk("ctl outs", {29'h0, o_ltr_en, o_hint_en}, 32'h7);
    wr(PCS_OFF_DEV_CTL, 32'h0, 4'hd, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CTL, 32'h0000_6400, PCS_RESP_OKAY);
    wr(PCS_OFF_DEV_CTL, 32'h0000_2000, 4'h2, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CTL, 32'h0000_2000, PCS_RESP_OKAY);
    wr(PCS_OFF_LNK_CTL, 32'hffff_ffff, 4'hf, PCS_RESP_OKAY);
    rd(PCS_OFF_LNK_CTL, 32'h1fbf | dsel(), PCS_RESP_OKAY);
    chk("link outs", 32'({o_compliance_deemp, o_compliance_sos, o_mod_compliance, o_margin,
      o_deemp_sel, o_autospeed_dis, o_enter_compliance, o_target_speed}),
      32'h1fbf | {25'h0, dn, 6'h0});
    $display("controls done");
  endtask
  // Loader word replaces read-only defaults
  task automatic t_preload();
    wr(PCS_OFF_PRELOAD, 32'hffff_fff5, 4'h1, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CAP, 32'h0008_1800, PCS_RESP_OKAY);
    rd(PCS_OFF_PRELOAD, 32'h5, PCS_RESP_OKAY);
    chk("select", 32'(o_deemp_sel), 32'h0);
    wr(PCS_OFF_PRELOAD, 32'h8, 4'h1, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CAP, 32'h0000_0800, PCS_RESP_OKAY);
    chk("select", 32'(o_deemp_sel), 32'h1);
    // Live level from the link must show in status, apart from the strap
    i_cur_deemp <= !dn;
    rd(PCS_OFF_LNK_CTL, 32'h1fff | {15'h0, !dn, 16'h0}, PCS_RESP_OKAY);
    i_cur_deemp <= dn;
    $display("preload done");
  endtask
  // Unmapped and read-only words
  task automatic t_refuse();
    rd(8'he0, 32'h0, PCS_RESP_SLVERR);
    wr(8'he0, 32'hffff_ffff, 4'hf, PCS_RESP_SLVERR);
    wr(PCS_OFF_DEV_CAP, 32'hffff_ffff, 4'hf, PCS_RESP_OKAY);
    rd(PCS_OFF_DEV_CAP, 32'h0000_0800, PCS_RESP_OKAY);
    wr(PCS_OFF_SLT_CTL, 32'hffff_ffff, 4'hf, PCS_RESP_OKAY);
    rd(PCS_OFF_SLT_CTL, 32'h0, PCS_RESP_OKAY);
    $display("refuse done");
  endtask
  // Main sequence, both port directions
  initial
  begin
    {i_rst_n, i_downstream, i_cur_deemp, i_awvalid, i_wvalid, i_bready} = 6'h0;
    {i_arvalid, i_rready, i_awaddr, i_araddr, i_awprot, i_arprot} = 24'h0;
    i_wdata = 32'h0;
    i_wstrb = 4'h0;
    mismatches = 0;
    checks = 0;
    do_reset(1'b0);
    t_defaults();
    t_controls();
    t_preload();
    t_refuse();
    do_reset(1'b1);
    t_defaults();
    t_controls();
    t_preload();
    report_and_stop();
  end
endmodule
`default_nettype wire
